// >>> prox_irq.sv
`timescale 1ns/100ps
// Behaviour
// (R1) proximity result bytes at 87h and 88h
// (R2) proximity result bytes ignore host writes
// (R3) persistence code selects power-of-two count
// (R4) interrupt after that many consecutive exceedings
// (R5) data-ready enables raise ready interrupts
// (R6) window enable gates threshold interrupts
// (R7) select bit chooses proximity or ambient
// (R8) low threshold at 8Ah and 8Bh
// (R9) high threshold at 8Ch and 8Dh
// (R10) threshold bytes are host read/write
// (R11) interrupt control register at 89h
// (R12) status sticky until host writes one
// (R13) interrupt pin low while status set
// (R14) read returns byte then advances pointer
// (R15) in-window measurement restarts the counter
// (R16) strictly outside counts; direction recorded
module prox_irq #(
  parameter logic [6:0] TARGET_ADDR = prox_irq_pkg::TARGET_ADDR_DEF
) (
  input wire logic I_SYS_CLK,
  input wire logic I_RST,
  input wire logic I_SCL,
  input wire logic I_SDA,
  output logic O_SDA_OUT,
  output logic O_SDA_OE,
  input wire logic [15:0] I_PROX_DATA,
  input wire logic I_PROX_VALID,
  input wire logic [15:0] I_ALS_DATA,
  input wire logic I_ALS_VALID,
  output logic O_INT_N
);
  logic [2:0] scl_sync_ff;
  logic [2:0] sda_sync_ff;
  logic scl_lvl_ff;
  logic sda_lvl_ff;
  prox_irq_pkg::link_state_t state_ff;
  logic [3:0] bitcnt_ff;
  logic [7:0] shift_ff;
  logic [7:0] ptr_ff;
  logic first_ff;
  logic wr_pulse_ff;
  logic [7:0] wr_addr_ff;
  logic [7:0] wr_data_ff;
  logic sda_oe_ff;
  logic [15:0] prox_ff;
  logic [7:0] ctrl_ff;
  logic [15:0] low_th_ff;
  logic [15:0] high_th_ff;
  logic [7:0] status_ff;
  logic [7:0] cnt_ff;
  logic int_n_ff;

  // three-stage pin synchronisers, level taken when stages two and three agree
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      scl_sync_ff <= 3'h7;
      sda_sync_ff <= 3'h7;
      scl_lvl_ff <= 1'b1;
      sda_lvl_ff <= 1'b1;
    end else begin
      scl_sync_ff <= {scl_sync_ff[1:0], I_SCL};
      sda_sync_ff <= {sda_sync_ff[1:0], I_SDA};
      if (scl_sync_ff[1] == scl_sync_ff[2]) begin
        scl_lvl_ff <= scl_sync_ff[2];
      end
      if (sda_sync_ff[1] == sda_sync_ff[2]) begin
        sda_lvl_ff <= sda_sync_ff[2];
      end
    end
  end

  wire scl_new = (scl_sync_ff[1] == scl_sync_ff[2]) ? scl_sync_ff[2] : scl_lvl_ff;
  wire sda_new = (sda_sync_ff[1] == sda_sync_ff[2]) ? sda_sync_ff[2] : sda_lvl_ff;
  wire scl_rise = scl_new && !scl_lvl_ff;
  wire scl_fall = !scl_new && scl_lvl_ff;
  wire bus_start = scl_lvl_ff && scl_new && sda_lvl_ff && !sda_new;
  wire bus_stop = scl_lvl_ff && scl_new && !sda_lvl_ff && sda_new;
  wire byte_done = (bitcnt_ff == prox_irq_pkg::BITS_PER_BYTE);
  wire addr_hit = (shift_ff[7:1] == TARGET_ADDR);
  wire is_read = shift_ff[0];
  wire load_rd = scl_fall && (((state_ff == prox_irq_pkg::ST_ADDR_ACK) && is_read)
                 || (state_ff == prox_irq_pkg::ST_RD_ACK));

  // read data selection by pointer
  wire sel_prox_hi = (ptr_ff == prox_irq_pkg::ADDR_PROX_HI);
  wire sel_prox_lo = (ptr_ff == prox_irq_pkg::ADDR_PROX_LO);
  wire sel_ctrl = (ptr_ff == prox_irq_pkg::ADDR_IRQ_CTRL);
  wire sel_lowth_hi = (ptr_ff == prox_irq_pkg::ADDR_LOWTH_HI);
  wire sel_lowth_lo = (ptr_ff == prox_irq_pkg::ADDR_LOWTH_LO);
  wire sel_highth_hi = (ptr_ff == prox_irq_pkg::ADDR_HIGHTH_HI);
  wire sel_highth_lo = (ptr_ff == prox_irq_pkg::ADDR_HIGHTH_LO);
  wire sel_stat = (ptr_ff == prox_irq_pkg::ADDR_IRQ_STAT);
  wire [7:0] rd_data = sel_prox_hi ? prox_ff[15:8] : // R1
                       sel_prox_lo ? prox_ff[7:0] : // R1
                       sel_ctrl ? ctrl_ff :
                       sel_lowth_hi ? low_th_ff[15:8] : // R10
                       sel_lowth_lo ? low_th_ff[7:0] : // R10
                       sel_highth_hi ? high_th_ff[15:8] : // R10
                       sel_highth_lo ? high_th_ff[7:0] : // R10
                       sel_stat ? status_ff : prox_irq_pkg::RESET_BYTE;

  // serial target engine
  always_ff @(posedge I_SYS_CLK) begin
    wr_pulse_ff <= 1'b0;
    if (I_RST) begin
      state_ff <= prox_irq_pkg::ST_IDLE;
      bitcnt_ff <= 4'h0;
      shift_ff <= prox_irq_pkg::RESET_BYTE;
      ptr_ff <= prox_irq_pkg::RESET_BYTE;
      first_ff <= 1'b0;
      wr_addr_ff <= prox_irq_pkg::RESET_BYTE;
      wr_data_ff <= prox_irq_pkg::RESET_BYTE;
      sda_oe_ff <= 1'b0;
    end else if (bus_start) begin
      state_ff <= prox_irq_pkg::ST_ADDR;
      bitcnt_ff <= 4'h0;
      sda_oe_ff <= 1'b0;
    end else if (bus_stop) begin
      state_ff <= prox_irq_pkg::ST_IDLE;
      sda_oe_ff <= 1'b0;
    end else begin
      case (state_ff)
        prox_irq_pkg::ST_ADDR, prox_irq_pkg::ST_WRITE: begin
          if (scl_rise && !byte_done) begin
            shift_ff <= {shift_ff[6:0], sda_lvl_ff};
            bitcnt_ff <= bitcnt_ff + 4'h1;
          end else if (scl_fall && byte_done) begin
            bitcnt_ff <= 4'h0;
            if (state_ff == prox_irq_pkg::ST_ADDR) begin
              sda_oe_ff <= addr_hit;
              first_ff <= !is_read;
              state_ff <= addr_hit ? prox_irq_pkg::ST_ADDR_ACK : prox_irq_pkg::ST_IDLE;
            end else begin
              sda_oe_ff <= 1'b1;
              state_ff <= prox_irq_pkg::ST_WR_ACK;
              first_ff <= 1'b0;
              if (first_ff) begin
                ptr_ff <= shift_ff;
              end else begin
                wr_pulse_ff <= 1'b1;
                wr_addr_ff <= ptr_ff;
                wr_data_ff <= shift_ff;
                ptr_ff <= ptr_ff + 8'h01;
              end
            end
          end
        end
        prox_irq_pkg::ST_ADDR_ACK, prox_irq_pkg::ST_WR_ACK: begin
          if (scl_fall && !load_rd) begin
            sda_oe_ff <= 1'b0;
            state_ff <= prox_irq_pkg::ST_WRITE;
          end
        end
        prox_irq_pkg::ST_READ: begin
          if (scl_fall && byte_done) begin
            sda_oe_ff <= 1'b0;
            state_ff <= prox_irq_pkg::ST_RD_ACK;
          end else if (scl_fall) begin
            sda_oe_ff <= !shift_ff[7];
            shift_ff <= {shift_ff[6:0], 1'b0};
            bitcnt_ff <= bitcnt_ff + 4'h1;
          end
        end
        prox_irq_pkg::ST_RD_ACK: begin
          if (scl_rise && sda_lvl_ff) begin
            state_ff <= prox_irq_pkg::ST_IDLE;
          end
        end
        default: begin
          sda_oe_ff <= 1'b0;
        end
      endcase
      if (load_rd) begin
        state_ff <= prox_irq_pkg::ST_READ;
        sda_oe_ff <= !rd_data[7];
        shift_ff <= {rd_data[6:0], 1'b0};
        bitcnt_ff <= 4'h1;
        ptr_ff <= ptr_ff + 8'h01; // R14
      end
    end
  end

  // register writes
  wire wr_ctrl = wr_pulse_ff && (wr_addr_ff == prox_irq_pkg::ADDR_IRQ_CTRL); // R11
  wire wr_stat = wr_pulse_ff && (wr_addr_ff == prox_irq_pkg::ADDR_IRQ_STAT);
  wire wr_lowth_hi = wr_pulse_ff && (wr_addr_ff == prox_irq_pkg::ADDR_LOWTH_HI); // R8
  wire wr_lowth_lo = wr_pulse_ff && (wr_addr_ff == prox_irq_pkg::ADDR_LOWTH_LO); // R8
  wire wr_highth_hi = wr_pulse_ff && (wr_addr_ff == prox_irq_pkg::ADDR_HIGHTH_HI); // R9
  wire wr_highth_lo = wr_pulse_ff && (wr_addr_ff == prox_irq_pkg::ADDR_HIGHTH_LO); // R9

  // window comparison
  wire win_sel = ctrl_ff[prox_irq_pkg::CTRL_WIN_SEL];
  wire [15:0] sample = win_sel ? I_ALS_DATA : I_PROX_DATA; // R7
  wire sample_valid = win_sel ? I_ALS_VALID : I_PROX_VALID; // R7
  wire above = sample > high_th_ff; // R16
  wire below = sample < low_th_ff; // R16
  wire in_window = !above && !below;
  wire [2:0] pers = ctrl_ff[prox_irq_pkg::CTRL_PERS_MSB:prox_irq_pkg::CTRL_PERS_LSB];
  wire [7:0] req_count = prox_irq_pkg::ONE_COUNT << pers; // R3
  wire fire = sample_valid && !in_window && ((cnt_ff + 8'h01) >= req_count); // R4
  wire win_en = ctrl_ff[prox_irq_pkg::CTRL_WIN_EN];
  wire [7:0] evt;
  assign evt[7:4] = 4'h0;
  assign evt[prox_irq_pkg::STAT_PROX_RDY] = I_PROX_VALID && ctrl_ff[prox_irq_pkg::CTRL_PROX_EN]; // R5
  assign evt[prox_irq_pkg::STAT_ALS_RDY] = I_ALS_VALID && ctrl_ff[prox_irq_pkg::CTRL_ALS_EN]; // R5
  assign evt[prox_irq_pkg::STAT_BELOW] = fire && below && win_en; // R6
  assign evt[prox_irq_pkg::STAT_ABOVE] = fire && above && win_en; // R6
  wire [7:0] clr = wr_stat ? (wr_data_ff & prox_irq_pkg::STAT_WMASK) : 8'h00;
  wire [7:0] nxt_status = evt | (status_ff & ~clr); // R12
  wire [7:0] nxt_cnt = (!sample_valid) ? cnt_ff :
                       (in_window || fire) ? 8'h00 : (cnt_ff + 8'h01); // R15

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      prox_ff <= 16'h0000;
      ctrl_ff <= prox_irq_pkg::RESET_BYTE;
      low_th_ff <= 16'h0000;
      high_th_ff <= 16'h0000;
      status_ff <= prox_irq_pkg::RESET_BYTE;
      cnt_ff <= 8'h00;
      int_n_ff <= 1'b1;
    end else begin
      if (I_PROX_VALID) begin
        prox_ff <= I_PROX_DATA; // R2
      end
      if (wr_ctrl) begin
        ctrl_ff <= wr_data_ff & prox_irq_pkg::CTRL_WMASK;
      end
      if (wr_lowth_hi) begin
        low_th_ff[15:8] <= wr_data_ff;
      end
      if (wr_lowth_lo) begin
        low_th_ff[7:0] <= wr_data_ff;
      end
      if (wr_highth_hi) begin
        high_th_ff[15:8] <= wr_data_ff;
      end
      if (wr_highth_lo) begin
        high_th_ff[7:0] <= wr_data_ff;
      end
      status_ff <= nxt_status;
      cnt_ff <= nxt_cnt;
      int_n_ff <= ~|nxt_status; // R13
    end
  end

  assign O_SDA_OUT = 1'b0;
  assign O_SDA_OE = sda_oe_ff;
  assign O_INT_N = int_n_ff;

  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RST);

  sequence s_prox_event;
    I_PROX_VALID && ctrl_ff[prox_irq_pkg::CTRL_PROX_EN];
  endsequence
  sequence s_als_event;
    I_ALS_VALID && ctrl_ff[prox_irq_pkg::CTRL_ALS_EN];
  endsequence

  a_prox_readonly: assert property ( // R2
    (wr_pulse_ff && wr_addr_ff == prox_irq_pkg::ADDR_PROX_HI && !I_PROX_VALID)
    |=> $stable(prox_ff)) else $error("proximity result changed by host write");
  a_pin_follows: assert property ( // R13
    ##1 (O_INT_N == !(|status_ff))) else $error("interrupt pin disagrees with status");
  a_status_sticky: assert property ( // R12
    (status_ff[prox_irq_pkg::STAT_ABOVE] && !(wr_stat && wr_data_ff[prox_irq_pkg::STAT_ABOVE]))
    |=> status_ff[prox_irq_pkg::STAT_ABOVE]) else $error("status bit lost without clear");
  a_prox_ready: assert property (s_prox_event |=> status_ff[prox_irq_pkg::STAT_PROX_RDY]) // R5
    else $error("proximity ready not flagged");
  a_als_ready: assert property (s_als_event |=> status_ff[prox_irq_pkg::STAT_ALS_RDY]) // R5
    else $error("ambient ready not flagged");
  a_window_gate: assert property ( // R6
    $rose(status_ff[prox_irq_pkg::STAT_ABOVE]) |-> $past(win_en) && $past(above))
    else $error("above flag without enable or exceeding");
  a_window_restart: assert property ((sample_valid && in_window) |=> cnt_ff == 8'h00) // R15
    else $error("counter not restarted inside window");
  a_single_count: assert property ( // R3
    (sample_valid && below && pers == 3'b000 && win_en)
    |=> status_ff[prox_irq_pkg::STAT_BELOW]) else $error("single count did not fire");
  a_ptr_advance: assert property (load_rd |=> ptr_ff == $past(ptr_ff) + 8'h01) // R14
    else $error("pointer did not advance after read");
  a_high_write: assert property ( // R10
    wr_highth_hi |=> high_th_ff[15:8] == $past(wr_data_ff)) else $error("threshold not stored");
endmodule : prox_irq

// >>> prox_irq_pkg.sv
package prox_irq_pkg;
  // register pointer values
  localparam logic [7:0] ADDR_PROX_HI = 8'h87;
  localparam logic [7:0] ADDR_PROX_LO = 8'h88;
  localparam logic [7:0] ADDR_IRQ_CTRL = 8'h89;
  localparam logic [7:0] ADDR_LOWTH_HI = 8'h8A;
  localparam logic [7:0] ADDR_LOWTH_LO = 8'h8B;
  localparam logic [7:0] ADDR_HIGHTH_HI = 8'h8C;
  localparam logic [7:0] ADDR_HIGHTH_LO = 8'h8D;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h8E;
  // control field positions
  localparam int CTRL_PERS_MSB = 7;
  localparam int CTRL_PERS_LSB = 5;
  localparam int CTRL_PROX_EN = 3;
  localparam int CTRL_ALS_EN = 2;
  localparam int CTRL_WIN_EN = 1;
  localparam int CTRL_WIN_SEL = 0;
  // status field positions
  localparam int STAT_PROX_RDY = 3;
  localparam int STAT_ALS_RDY = 2;
  localparam int STAT_BELOW = 1;
  localparam int STAT_ABOVE = 0;
  localparam logic [7:0] CTRL_WMASK = 8'hEF;
  localparam logic [7:0] STAT_WMASK = 8'h0F;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] ONE_COUNT = 8'h01;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // target address, arbitrary value
  localparam logic [6:0] TARGET_ADDR_DEF = 7'h2A;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ADDR_ACK = 3'b010,
    ST_WRITE = 3'b011,
    ST_WR_ACK = 3'b100,
    ST_READ = 3'b101,
    ST_RD_ACK = 3'b110
  } link_state_t;
endpackage : prox_irq_pkg

// >>> i2c_host_model.sv
`timescale 1ns/100ps
module i2c_host_model (
  input wire logic i_clk,
  input wire logic i_dev_oe,
  output logic o_scl,
  output logic o_sda
);
  logic scl_drv = 1'b1;
  logic sda_low = 1'b0;
  // open drain with pull-up
  assign o_sda = !(sda_low || i_dev_oe);
  assign o_scl = scl_drv;
  task automatic wt(input int n);
    repeat (n) @(posedge i_clk);
  endtask : wt
  // data moves mid low phase, clear of the filtered clock edge
  task automatic put_bit(input logic b);
    wt(4);
    sda_low <= !b;
    wt(4);
    scl_drv <= 1'b1;
    wt(8);
    scl_drv <= 1'b0;
  endtask : put_bit
  task automatic get_bit(output logic b);
    wt(4);
    sda_low <= 1'b0;
    wt(4);
    scl_drv <= 1'b1;
    wt(8);
    b = o_sda;
    scl_drv <= 1'b0;
  endtask : get_bit
  task automatic start_c;
    wt(4);
    sda_low <= 1'b0;
    wt(4);
    scl_drv <= 1'b1;
    wt(8);
    sda_low <= 1'b1;
    wt(8);
    scl_drv <= 1'b0;
  endtask : start_c
  task automatic stop_c;
    wt(4);
    sda_low <= 1'b1;
    wt(4);
    scl_drv <= 1'b1;
    wt(8);
    sda_low <= 1'b0;
    wt(8);
  endtask : stop_c
  task automatic send(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(ack);
    ack = !ack;
  endtask : send
  task automatic recv(input logic last, output logic [7:0] d);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      get_bit(b);
      d[i] = b;
    end
    put_bit(last);
  endtask : recv
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic k1, k2, k3;
    start_c;
    send({prox_irq_pkg::TARGET_ADDR_DEF, 1'b0}, k1);
    send(a, k2);
    send(d, k3);
    stop_c;
    ok = k1 & k2 & k3;
  endtask : write_reg
  // address-only probe, answers whether a target acknowledged
  task automatic probe(input logic [6:0] t, output logic ack);
    start_c;
    send({t, 1'b0}, ack);
    stop_c;
  endtask : probe
  // pointer write, repeated start, then auto-increment reads
  task automatic read_seq(input logic [7:0] a, input int n, output logic [55:0] q);
    logic k;
    logic [7:0] d;
    q = '0;
    start_c;
    send({prox_irq_pkg::TARGET_ADDR_DEF, 1'b0}, k);
    send(a, k);
    start_c;
    send({prox_irq_pkg::TARGET_ADDR_DEF, 1'b1}, k);
    for (int i = 0; i < n; i++) begin
      recv(i == n - 1, d);
      q = {q[47:0], d};
    end
    stop_c;
  endtask : read_seq
endmodule : i2c_host_model

// >>> proximity_threshold_interrupt_test.sv
`timescale 1ns/100ps
module proximity_threshold_interrupt_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic scl, sda, oe, ok, below, sel;
  logic [15:0] prox_d = 16'h0000;
  logic [15:0] als_d = 16'h0000;
  logic prox_v = 1'b0;
  logic als_v = 1'b0;
  logic [55:0] q, exp;
  logic [15:0] pv, v, inwin;
  int miscompares = 0;
  int tests_run = 0;
  int seed = 29315;
  always #25 clk = !clk;
  logic int_n, sda_out;
  prox_irq dut_u (.I_SYS_CLK(clk), .I_RST(rst), .I_SCL(scl), .I_SDA(sda), .O_SDA_OUT(sda_out),
    .O_SDA_OE(oe), .I_PROX_DATA(prox_d), .I_PROX_VALID(prox_v), .I_ALS_DATA(als_d),
    .I_ALS_VALID(als_v), .O_INT_N(int_n));
  i2c_host_model host_u (.i_clk(clk), .i_dev_oe(oe), .o_scl(scl), .o_sda(sda));
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk8
  task automatic chk1(input logic g, input logic e);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk1
  // expected status byte with a single flag set
  function automatic logic [7:0] flag_bit(input int pos);
    return 8'h01 << pos;
  endfunction : flag_bit
  task automatic final_report;
    if (miscompares == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host_u.write_reg(a, d, ok);
    chk1(ok, 1'b1);
  endtask : wr
  // one measurement on both channels, then let the pin settle
  task automatic smp(input logic [15:0] p, input logic [15:0] a);
    @(posedge clk);
    prox_d <= p;
    als_d <= a;
    prox_v <= 1'b1;
    als_v <= 1'b1;
    @(posedge clk);
    prox_v <= 1'b0;
    als_v <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask : smp
  task automatic smp_sel(input logic [15:0] x);
    if (sel) smp(16'h1800, x);
    else smp(x, 16'h1800);
  endtask : smp_sel
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    host_u.read_seq(8'h87, 7, q);
    for (int j = 0; j < 7; j++) chk8(q[8*j+:8], 8'h00);
    chk1(sda_out, 1'b0);
    for (int j = 0; j < 6; j++) exp[8*j+:8] = 8'($random(seed));
    exp[55:40] = 16'h0000;
    wr(8'h87, 8'($random(seed)));
    for (int j = 0; j < 5; j++) wr(8'h89 + 8'(j), exp[8*(4-j)+:8]);
    exp[39:32] = exp[39:32] & prox_irq_pkg::CTRL_WMASK;
    host_u.read_seq(8'h87, 7, q);
    for (int j = 0; j < 7; j++) chk8(q[8*j+:8], exp[8*j+:8]);
    host_u.read_seq(8'h20, 1, q);
    chk8(q[7:0], 8'h00);
    host_u.probe(~prox_irq_pkg::TARGET_ADDR_DEF, ok);
    chk1(ok, 1'b0);
    wr(prox_irq_pkg::ADDR_IRQ_CTRL, 8'h00);
    pv = 16'($random(seed));
    smp(pv, 16'h1800);
    chk1(int_n, 1'b1);
    wr(8'h88, ~pv[7:0]);
    host_u.read_seq(8'h87, 2, q);
    chk8(q[15:8], pv[15:8]);
    chk8(q[7:0], pv[7:0]);
    wr(8'h8A, 8'h10);
    wr(8'h8B, 8'h00);
    wr(8'h8C, 8'h20);
    wr(8'h8D, 8'h00);
    for (int c = 0; c < 8; c++) begin
      sel = c[0];
      below = c[1];
      v = below ? 16'h0FFF : 16'h2001;
      inwin = below ? 16'h1000 : 16'h2000;
      wr(prox_irq_pkg::ADDR_IRQ_CTRL, {c[2:0], 5'h02} | {7'h00, sel});
      wr(prox_irq_pkg::ADDR_IRQ_STAT, 8'h0F);
      repeat ((1 << c) - 1) smp_sel(v);
      smp_sel(inwin);
      repeat ((1 << c) - 1) smp_sel(v);
      chk1(int_n, 1'b1);
      smp_sel(v);
      chk1(int_n, 1'b0);
      host_u.read_seq(prox_irq_pkg::ADDR_IRQ_STAT, 1, q);
      exp[7:0] = flag_bit(below ? prox_irq_pkg::STAT_BELOW : prox_irq_pkg::STAT_ABOVE);
      chk8(q[7:0], exp[7:0]);
      wr(prox_irq_pkg::ADDR_IRQ_STAT, 8'h0F);
      chk1(int_n, 1'b1);
    end
    wr(prox_irq_pkg::ADDR_IRQ_CTRL, 8'h00);
    repeat (3) smp(16'h2001, 16'h2001);
    chk1(int_n, 1'b1);
    for (int b = 0; b < 2; b++) begin
      wr(prox_irq_pkg::ADDR_IRQ_CTRL, b ? 8'h04 : 8'h08);
      smp(16'h1800, 16'h1800);
      chk1(int_n, 1'b0);
      host_u.read_seq(prox_irq_pkg::ADDR_IRQ_STAT, 1, q);
      exp[7:0] = flag_bit(b ? prox_irq_pkg::STAT_ALS_RDY : prox_irq_pkg::STAT_PROX_RDY);
      chk8(q[7:0], exp[7:0]);
      wr(prox_irq_pkg::ADDR_IRQ_STAT, 8'h0F);
    end
    final_report;
  end
  initial begin
    repeat (90000) @(posedge clk);
    miscompares++;
    final_report;
  end
endmodule : proximity_threshold_interrupt_test
